// [rtl/p1g_defines.vh]
// register offsets, field positions and reset values for the port 1 pin mux
`ifndef P1G_DEFINES_VH
`define P1G_DEFINES_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define P1G_ADDR_DIR 16'hFF80
`define P1G_ADDR_DATA 16'hFF82
`define P1G_ADDR_CTRL 16'hFFFC

// ----------------------------------------
// reset values
// ----------------------------------------
`define P1G_DIR_RESET 8'h03
`define P1G_DIR_HWSTBY 8'h00
`define P1G_DATA_RESET 6'h00
`define P1G_CTRL_RESET 8'h87
`define P1G_CTRL_FIXED_MASK 8'h87
`define P1G_DIR_READ 8'hFF

// ----------------------------------------
// control register fields
// ----------------------------------------
`define P1G_CTRL_EXT_INT_ONE_INPUT 6
`define P1G_CTRL_EXT_INT_ZERO_INPUT 5
`define P1G_CTRL_NMI 4
`define P1G_CTRL_BREL 3

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define P1G_MODE_SINGLE 3'h7

`endif

// [rtl/p1g_sync2.v]
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module p1g_sync2 #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // first stage feeds only the second stage
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule // p1g_sync2

`default_nettype wire

// [rtl/p1g_port1_gpio_pin_mux.v]
// port 1 general-purpose pins with timer, interrupt, wait, bus-release and clock sharing
// What this block does
// - modes 1-4 expanded, mode 7 single-chip
// - direction bit 1 output, 0 input
// - direction register write-only, reads all ones
// - reset loads direction with 03
// - hardware standby clears direction to 00
// - software standby keeps direction unchanged
// - data read: latch if output, else pin; pins 1,0 as outputs read the clocks, pins 6,5 read the pin as interrupts
// - data bits 1:0 read-only, 7:2 reset zero
// - pins 1,0 output E and system clocks
// - control resets to 87, kept in software standby
// - control bits 7,2:0 fixed, read one
// - control bit 6 makes pin 6 interrupt 1
// - control bit 5 makes pin 5 interrupt 0
// - control bit 4 picks nonmaskable edge
// - bus release on pins 3,2 expanded only
// - any timer select bit drives pin 7
// - wait select makes pin 4 wait input
// - single-chip: pins 4,3,2 plain port only
`timescale 1ns/1ps
`default_nettype none
`include "p1g_defines.vh"

module p1g_port1_gpio_pin_mux (
   input wire clk,
   input wire arst_n,
   // hardware standby, active low, from the standby pin logic
   input wire hw_standby_n,
   // operating mode pins, already stable at the device level
   input wire [2:0] op_mode,
   // cpu register access
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   output reg [7:0] cpu_rdata,
   output wire cpu_hit,
   // on-chip sources and sinks
   input wire [3:0] timer_output_select_bits,
   input wire timer8_compare_output,
   input wire wait_select_high_bit,
   input wire e_clock,
   input wire sys_clock,
   input wire bus_ack_out,
   output wire ext_int_one_input,
   output wire ext_int_zero_input,
   output wire wait_input,
   output wire bus_request_input,
   output wire nonmaskable_edge_select,
   // pins: output enable is low while the block drives the pin
   input wire [7:0] pin_in,
   output reg [7:0] pin_out,
   output reg [7:0] pin_oe_n
);

   // ----------------------------------------
   // register state
   // ----------------------------------------
   reg [7:0] port_direction_reg_r;
   reg [7:2] port_data_reg_r;
   reg [6:3] ctrl_bits_r;
   wire [7:0] pin_sync;
   wire [7:0] port_function_ctrl_reg;
   wire expanded_mode;
   wire ext_int_one_pin_select;
   wire ext_int_zero_pin_select;
   wire bus_release_select;
   wire sel_dir;
   wire sel_data;
   wire sel_ctrl;
   reg [7:0] drive_en;
   reg [7:0] drive_val;
   reg [7:0] data_read;
   reg [7:0] cpu_rdata_nxt;
   // full reset image, so the writable field can be sliced out at its own width
   localparam [7:0] CTRL_RST = `P1G_CTRL_RESET;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   p1g_sync2 #(
      .WIDTH(8)
   ) u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // mode decode: anything but the single-chip code counts as expanded
   assign expanded_mode = (op_mode != `P1G_MODE_SINGLE);

   assign sel_dir = (cpu_addr == `P1G_ADDR_DIR);
   assign sel_data = (cpu_addr == `P1G_ADDR_DATA);
   assign sel_ctrl = (cpu_addr == `P1G_ADDR_CTRL);
   assign cpu_hit = sel_dir | sel_data | sel_ctrl;

   // ----------------------------------------
   // direction register
   // ----------------------------------------
   // hardware standby is a level; while held the register stays cleared.
   // software standby has no input here, so the register just holds.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_direction_reg_r <= `P1G_DIR_RESET;
      end else if (!hw_standby_n) begin
         port_direction_reg_r <= `P1G_DIR_HWSTBY;
      end else if (cpu_wr && sel_dir) begin
         port_direction_reg_r <= cpu_wdata;
      end
   end

   // ----------------------------------------
   // data latch, bits 7:2 only
   // ----------------------------------------
   // the latch takes writes whatever the direction, so a pin turned to
   // output later drives the value written beforehand
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_data_reg_r <= `P1G_DATA_RESET;
      end else if (!hw_standby_n) begin
         port_data_reg_r <= `P1G_DATA_RESET;
      end else if (cpu_wr && sel_data) begin
         port_data_reg_r <= cpu_wdata[7:2];
      end
   end

   // ----------------------------------------
   // control register, bits 6:3 writable
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_bits_r <= CTRL_RST[6:3];
      end else if (!hw_standby_n) begin
         ctrl_bits_r <= CTRL_RST[6:3];
      end else if (cpu_wr && sel_ctrl) begin
         ctrl_bits_r <= cpu_wdata[6:3];
      end
   end

   // fixed bits always read one, writes never reach them
   assign port_function_ctrl_reg = {1'b1, ctrl_bits_r, 3'h7};
   assign ext_int_one_pin_select = port_function_ctrl_reg[`P1G_CTRL_EXT_INT_ONE_INPUT];
   assign ext_int_zero_pin_select = port_function_ctrl_reg[`P1G_CTRL_EXT_INT_ZERO_INPUT];
   assign nonmaskable_edge_select = port_function_ctrl_reg[`P1G_CTRL_NMI];
   // bus release bit is dead in single-chip mode
   assign bus_release_select = port_function_ctrl_reg[`P1G_CTRL_BREL] & expanded_mode;

   // ----------------------------------------
   // pin function selection
   // ----------------------------------------
   always @* begin
      // general-purpose default: direction bit decides, latch drives
      drive_en = port_direction_reg_r;
      drive_val = {port_data_reg_r, sys_clock, e_clock};
      // clocks on pins 1 and 0 replace latch data when outputs
      drive_val[1] = e_clock;
      drive_val[0] = sys_clock;
      // timer output overrides the direction bit on pin 7
      if (timer_output_select_bits != 4'h0) begin
         drive_en[7] = 1'b1;
         drive_val[7] = timer8_compare_output;
      end
      // interrupt inputs float the pin regardless of direction
      if (ext_int_one_pin_select) begin
         drive_en[6] = 1'b0;
      end
      if (ext_int_zero_pin_select) begin
         drive_en[5] = 1'b0;
      end
      // wait input only exists with an external bus
      if (expanded_mode && wait_select_high_bit) begin
         drive_en[4] = 1'b0;
      end
      // bus release: pin 3 request in, pin 2 acknowledge out
      if (bus_release_select) begin
         drive_en[3] = 1'b0;
         drive_en[2] = 1'b1;
         drive_val[2] = bus_ack_out;
      end
      // single-chip leaves pins 4..2 as set above by direction only
   end

   // pin drivers are registered so pads see glitch-free levels
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= 8'h00;
         pin_oe_n <= 8'hFF;
      end else begin
         pin_out <= drive_val;
         pin_oe_n <= ~drive_en;
      end
   end

   // ----------------------------------------
   // alternate inputs to on-chip logic
   // ----------------------------------------
   // a function not selected reads as its inactive level (high)
   assign ext_int_one_input = ext_int_one_pin_select ? pin_sync[6] : 1'b1;
   assign ext_int_zero_input = ext_int_zero_pin_select ? pin_sync[5] : 1'b1;
   assign wait_input = (expanded_mode && wait_select_high_bit) ? pin_sync[4] : 1'b1;
   assign bus_request_input = bus_release_select ? pin_sync[3] : 1'b1;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // output pins read the latch, input pins the synchronised pin;
   // clock pins read the instantaneous clock rather than a latch
   always @* begin
      data_read[7:2] = (port_direction_reg_r[7:2] & port_data_reg_r) |
                       (~port_direction_reg_r[7:2] & pin_sync[7:2]);
      data_read[1] = port_direction_reg_r[1] ? e_clock : pin_sync[1];
      data_read[0] = port_direction_reg_r[0] ? sys_clock : pin_sync[0];
      // pins used by interrupt inputs still read their level
      if (ext_int_one_pin_select) begin
         data_read[6] = pin_sync[6];
      end
      if (ext_int_zero_pin_select) begin
         data_read[5] = pin_sync[5];
      end
   end

   always @* begin
      cpu_rdata_nxt = 8'h00;
      if (sel_dir) begin
         cpu_rdata_nxt = `P1G_DIR_READ;
      end else if (sel_data) begin
         cpu_rdata_nxt = data_read;
      end else if (sel_ctrl) begin
         cpu_rdata_nxt = port_function_ctrl_reg;
      end
   end

   // read data registered; valid the cycle after cpu_rd
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_rd) begin
         cpu_rdata <= cpu_rdata_nxt;
      end
   end

endmodule // p1g_port1_gpio_pin_mux

`default_nettype wire

// [sim/p1g_pad_model.sv]
// pad model standing outside the port 1 pins
`timescale 1ns/1ps
`default_nettype none
module p1g_pad_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_in
);
   // a released pad shows the outside level, a driven pad its own value
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // p1g_pad_model
`default_nettype wire

// [sim/p1g_mux_monitor.sv]
// assertions on the port 1 pin mux ports
`timescale 1ns/1ps
`default_nettype none
module p1g_mux_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hw_standby_n,
   input wire logic [2:0] op_mode,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_hit,
   input wire logic wait_input,
   input wire logic bus_request_input,
   input wire logic nonmaskable_edge_select,
   input wire logic [7:0] pin_oe_n,
   input wire logic [3:0] timer_output_select_bits
);
   // one domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_dir_reads_ones: assert property (cpu_rd && cpu_addr == 16'hFF80 |=> cpu_rdata == 8'hFF)
      else $error("dir read not ones");
   a_ctrl_fixed_ones: assert property (cpu_rd && cpu_addr == 16'hFFFC |=> cpu_rdata[7] && cpu_rdata[2:0] == 3'h7)
      else $error("ctrl fixed bits");
   a_nmi_edge_bit: assert property (cpu_wr && cpu_addr == 16'hFFFC && hw_standby_n
      |=> nonmaskable_edge_select == $past(cpu_wdata[4]))
      else $error("edge select");
   a_timer_owns_pin: assert property ((|timer_output_select_bits && hw_standby_n)[*2] |-> !pin_oe_n[7])
      else $error("timer pin");
   a_stby_stops_clk: assert property (!hw_standby_n[*2] |=> pin_oe_n[1:0] == 2'b11)
      else $error("standby clocks");
   a_single_chip_idle: assert property (op_mode == 3'h7 |-> wait_input && bus_request_input)
      else $error("single chip alt");
   // dir write reaches the pad two edges on; pin 4 is plain in single chip
   a_dir_sets_pin: assert property ((cpu_wr && cpu_addr == 16'hFF80 && hw_standby_n && op_mode == 3'h7)
      ##1 hw_standby_n |=> pin_oe_n[4] == !$past(cpu_wdata[4], 2))
      else $error("dir to pin");
   a_unmapped_zero: assert property (cpu_rd && !cpu_hit |=> cpu_rdata == 8'h00)
      else $error("unmapped read");
   c_dir_write: cover property (cpu_wr && cpu_addr == 16'hFF80);
   c_ctrl_read: cover property (cpu_rd && cpu_addr == 16'hFFFC);
   c_standby: cover property (!hw_standby_n);
endmodule // p1g_mux_monitor
bind p1g_port1_gpio_pin_mux p1g_mux_monitor i_p1g_mux_monitor (.clk, .arst_n, .hw_standby_n, .op_mode,
   .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_hit, .wait_input, .bus_request_input,
   .nonmaskable_edge_select, .pin_oe_n, .timer_output_select_bits);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the port 1 pin mux
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, hw_standby_n = 1'b1, cpu_rd = 1'b0, cpu_wr = 1'b0, bus_ack_out = 1'b1;
   logic timer8_compare_output = 1'b1, wait_select_high_bit = 1'b0, e_clock = 1'b1, sys_clock = 1'b0;
   logic [2:0] op_mode = 3'h7;
   logic [3:0] timer_output_select_bits = 4'h0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00, ext = 8'h00, d, w, c;
   wire [7:0] cpu_rdata, pin_in, pin_out, pin_oe_n;
   wire cpu_hit, ext_int_one_input, ext_int_zero_input, wait_input, bus_request_input, nonmaskable_edge_select;
   int failures = 0, comparisons = 0;
   p1g_port1_gpio_pin_mux i_p1g_port1_gpio_pin_mux (.clk, .arst_n, .hw_standby_n, .op_mode, .cpu_addr, .cpu_rd,
      .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_hit, .timer_output_select_bits, .timer8_compare_output,
      .wait_select_high_bit, .e_clock, .sys_clock, .bus_ack_out, .ext_int_one_input, .ext_int_zero_input,
      .wait_input, .bus_request_input, .nonmaskable_edge_select, .pin_in, .pin_out, .pin_oe_n);
   p1g_pad_model i_p1g_pad_model (.pin_out, .pin_oe_n, .ext_level(ext), .pin_in);
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic close_out;
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // pins wait two edges in the synchroniser, so settle before looking
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= v;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge clk);
      cpu_rd <= 1'b0;
      #1 chk("rdata", cpu_rdata, exp);
   endtask
   // outputs read the latch, inputs the pad; bits 1,0 as outputs read the clocks (e high, system low)
   function automatic logic [7:0] exp_rd(input logic [7:0] dd, input logic [7:0] ww, input logic [7:0] xx);
      return (dd & {ww[7:2], 2'b10}) | (~dd & xx);
   endfunction
   // a hang counts as a mismatch
   initial begin
      #100000;
      failures++;
      close_out;
   end
   // main sequence
   initial begin
      void'($urandom(32'h1F85));
      ext = 8'($urandom);
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      tick(3);
      chk("oe", pin_oe_n, 8'hFC);
      chk("clk_pins", pin_out[1:0], 8'h02);
      rd(16'hFF80, 8'hFF);
      rd(16'hFFFC, 8'h87);
      rd(16'hFF82, exp_rd(8'h03, 8'h00, ext));
      rd(16'h1234, 8'h00);
      chk("hit", cpu_hit, 8'h00);
      wr(16'hFF80, 8'hFF);
      tick(4);
      rd(16'hFF82, exp_rd(8'hFF, 8'h00, ext));
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h00 : 8'($urandom);
         w = 8'($urandom);
         @(posedge clk);
         ext <= 8'($urandom);
         wr(16'hFF80, 8'h03);
         wr(16'hFF82, w);
         wr(16'hFF80, d);
         tick(4);
         chk("oe", pin_oe_n, ~d);
         chk("out", pin_out & d & 8'hFC, w & d & 8'hFC);
         rd(16'hFF82, exp_rd(d, w, ext));
      end
      for (int j = 0; j < 2; j++) begin
         c = (8'($urandom) & 8'h87) | 8'h68 | {3'h0, j[0], 4'h0};
         wr(16'hFF80, 8'hFF);
         wr(16'hFFFC, c);
         tick(4);
         rd(16'hFFFC, (c & 8'h78) | 8'h87);
         chk("nmi", nonmaskable_edge_select, c[4]);
         chk("oe", pin_oe_n, 8'h60);
         chk("int", {ext_int_one_input, ext_int_zero_input, bus_request_input}, {ext[6:5], 1'b1});
         rd(16'hFF82, exp_rd(8'h9F, w, ext));
      end
      @(posedge clk);
      op_mode <= 3'h1;
      wait_select_high_bit <= 1'b1;
      tick(4);
      chk("exp", {pin_oe_n[4:2], pin_out[2]}, 8'h0D);
      chk("alt", {wait_input, bus_request_input}, ext[4:3]);
      @(posedge clk);
      wait_select_high_bit <= 1'b0;
      tick(4);
      chk("wait", {pin_oe_n[4], wait_input}, 8'h01);
      wr(16'hFF80, 8'h7F);
      timer_output_select_bits <= 4'(4'h1 << ($urandom % 4));
      tick(4);
      chk("tmr", {pin_oe_n[7], pin_out[7]}, 8'h01);
      @(posedge clk);
      timer_output_select_bits <= 4'h0;
      tick(4);
      chk("tmr", pin_oe_n[7], 8'h01);
      @(posedge clk);
      hw_standby_n <= 1'b0;
      tick(3);
      chk("stby", pin_oe_n, 8'hFF);
      @(posedge clk);
      hw_standby_n <= 1'b1;
      rd(16'hFFFC, 8'h87);
      close_out;
   end
endmodule // tb_top
`default_nettype wire
